// file: hw/pcie_link_power_state_lock.v
// link power state lock: holds the pcie link in L0 once lanes are up
`timescale 1ns/100ps
`default_nettype none
`include "link_pm_lock_defs.vh"
module pcie_link_power_state_lock
(
  input  wire              clk_sys,
  input  wire              rst_n,
  input  wire              lane_init_done,
  input  wire              sys_power_down,
  input  wire              sw_pm_req,
  input  wire [`LPS_W-1:0] sw_pm_state,
  input  wire              aspm_entry_req,
  input  wire              partner_eios,
  input  wire              adv_wr,
  input  wire [`ASPM_W-1:0] adv_wr_data,
  input  wire              ctl_wr,
  input  wire [`ASPM_W-1:0] ctl_wr_data,
  output reg  [`LPS_W-1:0] link_state_q,
  output reg               link_up_q,
  output reg               pm_req_blocked_q,
  output reg               partner_violation_q,
  output reg  [`ASPM_W-1:0] aspm_control_field_q,
  output reg  [`ASPM_W-1:0] aspm_support_advertise_field_q,
  output reg  [`REG_W-1:0] link_capability_reg_q
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // one synchroniser per pin, each slot named in the constants
  wire [`PIN_N-1:0] pin_raw;
  wire [`PIN_N-1:0] pin_s;
  wire              init_done_s;
  wire              eios_s;

  assign pin_raw[`PIN_INIT] = lane_init_done;
  assign pin_raw[`PIN_EIOS] = partner_eios;

  genvar g;
  generate
    for (g = 0; g < `PIN_N; g = g + 1)
    begin : g_sync
      pin_sync3 u_sync
      (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pin_in  (pin_raw[g]),
        .level_q (pin_s[g])
      );
    end
  endgenerate

  assign init_done_s = pin_s[`PIN_INIT];
  assign eios_s      = pin_s[`PIN_EIOS];

  // ****************************************************************
  // link power state machine
  // ****************************************************************
  // low power codes are named only so that they can be refused
  localparam [`LPS_W-1:0] ST_DETECT = `LPS_DETECT;
  localparam [`LPS_W-1:0] ST_TRAIN  = `LPS_TRAIN;
  localparam [`LPS_W-1:0] ST_L0     = `LPS_L0;
  localparam [`LPS_W-1:0] ST_L0S    = `LPS_L0S;
  localparam [`LPS_W-1:0] ST_L1     = `LPS_L1;
  localparam [`LPS_W-1:0] ST_L2     = `LPS_L2;
  localparam [`LPS_W-1:0] ST_OFF    = `LPS_OFF;

  reg [`LPS_W-1:0] state_d;
  reg              link_up_d;

  always @*
  begin
    state_d = link_state_q;
    case (link_state_q)
      ST_DETECT:
      begin
        state_d = ST_TRAIN;
      end
      ST_TRAIN:
      begin
        if (init_done_s)
          state_d = ST_L0;
      end
      ST_L0:
      begin
        // only a full system power down leaves L0; no idle detect exists
        if (sys_power_down)
          state_d = ST_OFF;
      end
      ST_OFF:
      begin
        if (!sys_power_down)
          state_d = ST_DETECT;
      end
      ST_L0S, ST_L1, ST_L2:
      begin
        // never entered; recover to L0 should an upset land here
        state_d = ST_L0;
      end
      default:
      begin
        state_d = ST_DETECT;
      end
    endcase
    if (sys_power_down && link_state_q != ST_L0)
      state_d = ST_OFF;
    link_up_d = (state_d == ST_L0);
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      link_state_q <= ST_DETECT;
    else
      link_state_q <= state_d;
  end

  // taken from the next state so the flag never lags the state output
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      link_up_q <= 1'b0;
    else
      link_up_q <= link_up_d;
  end

  // ****************************************************************
  // transition requests: refused, flagged sticky until power down
  // ****************************************************************
  wire sw_bad     = sw_pm_req && (sw_pm_state != ST_L0);
  wire eios_in_l0 = eios_s && (link_state_q == ST_L0);
  reg  pm_req_blocked_d;
  reg  partner_violation_d;

  // set wins over the power-down clear, so a request made in the
  // power-down cycle is never lost
  always @*
  begin
    pm_req_blocked_d = pm_req_blocked_q;
    if (sw_bad || aspm_entry_req)
      pm_req_blocked_d = 1'b1;
    else if (sys_power_down)
      pm_req_blocked_d = 1'b0;
  end

  // partner sent eios while the link should be in L0
  always @*
  begin
    partner_violation_d = partner_violation_q;
    if (eios_in_l0)
      partner_violation_d = 1'b1;
    else if (sys_power_down)
      partner_violation_d = 1'b0;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pm_req_blocked_q <= 1'b0;
    else
      pm_req_blocked_q <= pm_req_blocked_d;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      partner_violation_q <= 1'b0;
    else
      partner_violation_q <= partner_violation_d;
  end

  // ****************************************************************
  // aspm fields
  // ****************************************************************
  reg [`ASPM_W-1:0] aspm_control_field_d;
  reg [`ASPM_W-1:0] aspm_support_advertise_field_d;
  reg [`REG_W-1:0]  link_capability_reg_d;

  // control writes accepted but any enable bit is dropped, so no
  // write can arm an entry that would hang the link
  always @*
  begin
    aspm_control_field_d = aspm_control_field_q;
    if (ctl_wr)
      aspm_control_field_d = ctl_wr_data & `ASPM_NONE;
  end

  always @*
  begin
    aspm_support_advertise_field_d = aspm_support_advertise_field_q;
    if (adv_wr)
      aspm_support_advertise_field_d = adv_wr_data;
  end

  // capability word carries the advertise field one cycle late
  always @*
  begin
    link_capability_reg_d = {`REG_W{1'b0}};
    link_capability_reg_d[`CAP_ASPM_LSB+`ASPM_W-1:`CAP_ASPM_LSB] =
      aspm_support_advertise_field_q;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      aspm_control_field_q <= `ASPM_CTL_RESET;
    else
      aspm_control_field_q <= aspm_control_field_d;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      aspm_support_advertise_field_q <= `ASPM_ADV_RESET;
    else
      aspm_support_advertise_field_q <= aspm_support_advertise_field_d;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      link_capability_reg_q <= {`REG_W{1'b0}};
    else
      link_capability_reg_q <= link_capability_reg_d;
  end
endmodule
`default_nettype wire

// file: hw/link_pm_lock_defs.vh
// constants for the pcie link power state lock
// ****************************************************************
// How it works
// - after lane init, link enters and holds L0
// - never start power state transitions; no idle detect
// - keep lanes in L0; never command L1/L2
// - aspm control field forced to zero
// - advertise field resets to L0s; zero clears it
// ****************************************************************
`ifndef LINK_PM_LOCK_DEFS_VH
`define LINK_PM_LOCK_DEFS_VH

// link power states
`define LPS_W          3
`define LPS_DETECT     3'h0
`define LPS_TRAIN      3'h1
`define LPS_L0         3'h2
`define LPS_L0S        3'h3
`define LPS_L1         3'h4
`define LPS_L2         3'h5
`define LPS_OFF        3'h6

// aspm field encodings, two bits each
`define ASPM_W         2
`define ASPM_NONE      2'h0
`define ASPM_L0S       2'h1
`define ASPM_L1        2'h2
`define ASPM_BOTH      2'h3
`define ASPM_ADV_RESET 2'h1
`define ASPM_CTL_RESET 2'h0

// field positions inside the capability and control words
`define CAP_ASPM_LSB   10
`define CTL_ASPM_LSB   0
`define REG_W          32

// pin synchroniser slots
`define PIN_N          2
`define PIN_INIT       0
`define PIN_EIOS       1

`endif

// file: hw/pin_sync3.v
// three-stage synchroniser with agreement check for pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync3
(
  input  wire clk_sys,
  input  wire rst_n,
  input  wire pin_in,
  output reg  level_q
);
  reg s1_q;
  reg s2_q;
  reg s3_q;

  // s1 only feeds s2; change counts once s2 and s3 agree
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q    <= 1'b0;
      s2_q    <= 1'b0;
      s3_q    <= 1'b0;
      level_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        level_q <= s3_q;
    end
  end
endmodule
`default_nettype wire

// file: verification/link_pm_lock_sva.sv
// assertions on the link power state lock ports
`timescale 1ns/100ps
`default_nettype none
`include "link_pm_lock_defs.vh"
module link_pm_chk
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        lane_init_done,
  input wire logic        sys_power_down,
  input wire logic        sw_pm_req,
  input wire logic [2:0]  sw_pm_state,
  input wire logic        aspm_entry_req,
  input wire logic        adv_wr,
  input wire logic [1:0]  adv_wr_data,
  input wire logic [2:0]  link_state_q,
  input wire logic        link_up_q,
  input wire logic        pm_req_blocked_q,
  input wire logic [1:0]  aspm_control_field_q,
  input wire logic [1:0]  aspm_support_advertise_field_q,
  input wire logic [31:0] link_capability_reg_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // eight cycles covers the pin synchroniser plus the state step
  a_reach_l0: assert property ((lane_init_done && !sys_power_down)[*8] |->
    link_state_q == `LPS_L0) else $error("link not in L0");
  a_up_in_l0: assert property (link_up_q == (link_state_q == `LPS_L0))
    else $error("link up flag wrong");
  a_pm_refused: assert property ((sw_pm_req && sw_pm_state != `LPS_L0) || aspm_entry_req
    |=> pm_req_blocked_q) else $error("request not refused");
  a_no_low_state: assert property (!(link_state_q inside {`LPS_L0S, `LPS_L1, `LPS_L2}))
    else $error("low power state entered");
  a_ctl_zero: assert property (aspm_control_field_q == 2'h0) else $error("ctl nonzero");
  a_adv_write: assert property (adv_wr |=>
    aspm_support_advertise_field_q == $past(adv_wr_data)) else $error("advertise write");
  a_cap_lag: assert property (rst_n |=> link_capability_reg_q ==
    {20'h0, $past(aspm_support_advertise_field_q), 10'h0}) else $error("capability word");
endmodule
`default_nettype wire

// file: verification/link_partner_model.sv
// behavioural pcie link partner
`timescale 1ns/100ps
`default_nettype none
module link_partner_model
(
  input  wire logic clk_sys,
  input  wire logic inject_eios,
  output var  logic partner_eios
);
  localparam logic [1:0] PEER_ASPM_CTL = 2'h0;
  initial partner_eios = 1'b0;
  // idle sets go out only on a fault the bench commands
  always @(posedge clk_sys) partner_eios <= inject_eios && PEER_ASPM_CTL == 2'h0;
endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the link power state lock
`timescale 1ns/100ps
`default_nettype none
`include "link_pm_lock_defs.vh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module testbench;
  logic clk_sys, rst_n, lane_init_done, sys_power_down, sw_pm_req, aspm_entry_req, adv_wr;
  logic ctl_wr, inject_eios, partner_eios, link_up_q, pm_req_blocked_q, partner_violation_q;
  logic [2:0] sw_pm_state, link_state_q;
  logic [1:0] adv_wr_data, ctl_wr_data, aspm_control_field_q, aspm_support_advertise_field_q;
  logic [31:0] link_capability_reg_q;
  int mismatches, checks_done, cycles;
  // req, state, aspm, ctl wr, ctl data, adv wr, adv data | blocked, advertise
  logic [13:0] rows [5] = '{14'h2820, 14'h01C0, 14'h003B, 14'h0172, 14'h3006};
  pcie_link_power_state_lock dut_u (.clk_sys, .rst_n, .lane_init_done, .sys_power_down,
    .sw_pm_req, .sw_pm_state, .aspm_entry_req, .partner_eios, .adv_wr, .adv_wr_data, .ctl_wr,
    .ctl_wr_data, .link_state_q, .link_up_q, .pm_req_blocked_q, .partner_violation_q,
    .aspm_control_field_q, .aspm_support_advertise_field_q, .link_capability_reg_q);
  link_partner_model partner_u (.clk_sys, .inject_eios, .partner_eios);
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (++cycles == 2000) begin mismatches++; complete_run; end
  initial
  begin
    {rst_n, lane_init_done, sys_power_down, sw_pm_req, aspm_entry_req, inject_eios} = '0;
    {adv_wr, ctl_wr, sw_pm_state, adv_wr_data, ctl_wr_data} = '0;
    repeat (3) @(posedge clk_sys);
    `CHK("adv reset", 2'h1, aspm_support_advertise_field_q)
    rst_n <= 1'b1;
    lane_init_done <= 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 `CHK("up", 1'b1, link_up_q)
    `CHK("cap", 32'h400, link_capability_reg_q)
    foreach (rows[i])
    begin
      @(posedge clk_sys);
      {sw_pm_req, sw_pm_state, aspm_entry_req, ctl_wr, ctl_wr_data, adv_wr, adv_wr_data} <=
        rows[i][13:3];
      @(posedge clk_sys);
      {sw_pm_req, aspm_entry_req, ctl_wr, adv_wr} <= '0;
      #1 `CHK("blocked", rows[i][2], pm_req_blocked_q)
      `CHK("advertise", rows[i][1:0], aspm_support_advertise_field_q)
      `CHK("control", 2'h0, aspm_control_field_q)
      `CHK("state", `LPS_L0, link_state_q)
    end
    // power down clears the sticky flag, then the link comes back
    @(posedge clk_sys) sys_power_down <= 1'b1;
    @(posedge clk_sys) sys_power_down <= 1'b0;
    #1 `CHK("off", `LPS_OFF, link_state_q)
    `CHK("cleared", 1'b0, pm_req_blocked_q)
    repeat (8) @(posedge clk_sys) aspm_entry_req <= 1'b1;
    @(posedge clk_sys) aspm_entry_req <= 1'b0;
    #1 `CHK("aspm refused", 1'b1, pm_req_blocked_q)
    `CHK("held", `LPS_L0, link_state_q)
    @(posedge clk_sys) inject_eios <= 1'b1;
    repeat (7) @(posedge clk_sys);
    #1 `CHK("violation", 1'b1, partner_violation_q)
    `CHK("still l0", `LPS_L0, link_state_q)
    // set wins when a request meets the power-down clear
    @(posedge clk_sys) {inject_eios, sys_power_down, aspm_entry_req} <= 3'b011;
    @(posedge clk_sys) {sys_power_down, aspm_entry_req} <= 2'b00;
    #1 `CHK("set wins", 1'b1, pm_req_blocked_q)
    `CHK("pd off", `LPS_OFF, link_state_q)
    // mid-run reset restores the L0s advertisement and clears the flags
    @(posedge clk_sys) rst_n <= 1'b0;
    @(posedge clk_sys) rst_n <= 1'b1;
    #1 `CHK("rst adv", 2'h1, aspm_support_advertise_field_q)
    `CHK("rst blocked", 1'b0, pm_req_blocked_q)
    `CHK("rst state", `LPS_DETECT, link_state_q)
    repeat (8) @(posedge clk_sys);
    #1 `CHK("rst up", 1'b1, link_up_q)
    `CHK("rst eios", 1'b0, partner_violation_q)
    `CHK("rst cap", 32'h400, link_capability_reg_q)
    complete_run;
  end
endmodule
bind pcie_link_power_state_lock link_pm_chk chk_u (.clk_sys, .rst_n, .lane_init_done,
  .sys_power_down, .sw_pm_req, .sw_pm_state, .aspm_entry_req, .adv_wr, .adv_wr_data,
  .link_state_q, .link_up_q, .pm_req_blocked_q, .aspm_control_field_q,
  .aspm_support_advertise_field_q, .link_capability_reg_q);
`default_nettype wire
